// [design/pprs_pkg.sv]
// constants, field positions and route indices shared by the pin route block
package pprs_pkg;

  // ===========================================================
  // bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ===========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_LOGIC_EVENTS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COMM_PORTS   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_TIMER_A      = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_TIMER_B      = 4'h3;

  // ===========================================================
  // reset value and implemented-bit masks
  localparam logic [DATA_W-1:0] RST_VAL          = 8'h00;
  localparam logic [DATA_W-1:0] MASK_LOGIC       = 8'h37;
  localparam logic [DATA_W-1:0] MASK_COMM        = 8'h15;
  localparam logic [DATA_W-1:0] MASK_TIMER_A     = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_TIMER_B     = 8'h01;

  // ===========================================================
  // field positions
  localparam int EVENT_BIT     = 0;  // event outputs 0..2 at bits 0..2
  localparam int N_EVENT       = 3;
  localparam int LUT_BIT       = 4;  // lookup table 0 at bit 4, table 1 at bit 5
  localparam int COMM_BIT_STEP = 2;  // serial port bit 0, spi bit 2, two-wire bit 4
  localparam int WAVE_BIT      = 0;
  localparam int N_WAVE_FIXED  = 3;  // waves 0..2 route in every mode
  localparam int N_WAVE_SPLIT  = 3;  // waves 3..5 route only in split mode
  localparam int TIMER_B_BIT   = 0;

  // ===========================================================
  // routed signal index map
  localparam int N_LUT      = 2;
  localparam int N_WAVE     = 6;
  localparam int N_COMM     = 3;  // 0 serial port, 1 spi, 2 two-wire
  localparam int COMM_SIGS  = 4;
  localparam int LUT_BASE   = 0;
  localparam int WAVE_BASE  = 2;
  localparam int TB_BASE    = 8;
  localparam int COMM_BASE  = 9;
  localparam int N_ROUTE    = 21;

  typedef logic [N_ROUTE-1:0] pprs_route_t;
  typedef logic [N_EVENT-1:0] pprs_event_t;

endpackage

// [design/pprs_route_if.sv]
// select lines passed from the register file to the pin multiplexer
`timescale 1ns/10ps
interface pprs_route_if;
  import pprs_pkg::*;

  pprs_route_t routeAlt;  // one: use alternative pin
  pprs_event_t eventEn;   // one: drive event pin

  modport regs (output routeAlt, output eventEn);
  modport mux  (input  routeAlt, input  eventEn);
endinterface

// [design/pprs_route_mux.sv]
// per-signal default/alternative pin multiplexer with input synchronisers
`timescale 1ns/10ps
module pprs_route_mux (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // selects
  pprs_route_if.mux                  rif,
  // peripheral side
  input  wire pprs_pkg::pprs_route_t sigOut,
  input  wire pprs_pkg::pprs_route_t sigOe,
  output      pprs_pkg::pprs_route_t sigIn,
  input  wire pprs_pkg::pprs_event_t evOut,
  // pin side
  output      pprs_pkg::pprs_route_t defOut,
  output      pprs_pkg::pprs_route_t defOe,
  input  wire pprs_pkg::pprs_route_t defIn,
  output      pprs_pkg::pprs_route_t altOut,
  output      pprs_pkg::pprs_route_t altOe,
  input  wire pprs_pkg::pprs_route_t altIn,
  output      pprs_pkg::pprs_event_t evPinOut,
  output      pprs_pkg::pprs_event_t evPinOe
);
  import pprs_pkg::*;

  pprs_route_t defMeta;
  pprs_route_t defSync;
  pprs_route_t altMeta;
  pprs_route_t altSync;

  // pins are asynchronous; two stages before the select reads them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      defMeta <= '0;
      defSync <= '0;
      altMeta <= '0;
      altSync <= '0;
    end else begin
      defMeta <= defIn;
      defSync <= defMeta;
      altMeta <= altIn;
      altSync <= altMeta;
    end
  end

  // each route only follows its own select, so others never glitch
  genvar i;
  generate
    for (i = 0; i < N_ROUTE; i++) begin : g_route
      assign defOut[i] = rif.routeAlt[i] ? 1'b0 : sigOut[i];
      assign defOe[i]  = rif.routeAlt[i] ? 1'b0 : sigOe[i];
      assign altOut[i] = rif.routeAlt[i] ? sigOut[i] : 1'b0;
      assign altOe[i]  = rif.routeAlt[i] ? sigOe[i] : 1'b0;
      assign sigIn[i]  = rif.routeAlt[i] ? altSync[i] : defSync[i];
    end
    for (i = 0; i < N_EVENT; i++) begin : g_event
      // disabled event pins are released, not driven low
      assign evPinOut[i] = rif.eventEn[i] & evOut[i];
      assign evPinOe[i]  = rif.eventEn[i];
    end
  endgenerate

endmodule

// [design/pprs_pin_route_block.sv]
// pin route block: routing registers, select decode and pin multiplexer
//
// Behaviour
// - control bit 5 of the logic/event register moves lookup table 1 to its alternative pin.
// - control bit 4 of the logic/event register moves lookup table 0 to its alternative pin.
// - bit 2 enables event output 2; cleared, its pin is not driven.
// - bit 1 enables event output 1; cleared, its pin is not driven.
// - bit 0 enables event output 0; cleared, its pin is not driven.
// - comm register bit 4 moves the two-wire port pins to their alternative set.
// - comm register bit 2 moves the spi pins to their alternative set.
// - comm register bit 0 moves the serial port pins to their alternative set.
// - timer A bit 5 moves wave 5 to alternative pin in split mode.
// - timer A bit 4 moves wave 4 to alternative pin in split mode.
// - timer A bit 3 moves wave 3 to alternative pin in split mode.
// - bits for waves 3 to 5 do nothing in normal mode.
// - timer A bit 2 moves wave 2; in split mode the low-byte channel 2.
// - timer A bit 1 moves wave 1; in split mode the low-byte channel 1.
// - timer A bit 0 moves wave 0; in split mode the low-byte channel 0.
// - timer B register bit 0 moves the timer B output to its alternative pin.
// - all routing registers reset to zero: default pins, events off.
// - each route either enables a pin function or swaps default and alternative pin.
`timescale 1ns/10ps
module pprs_pin_route_block (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  // register port
  input  wire logic [pprs_pkg::ADDR_W-1:0]        busAddr,
  input  wire logic [pprs_pkg::DATA_W-1:0]        busWdata,
  input  wire logic                               busWe,
  input  wire logic                               busRe,
  output      logic [pprs_pkg::DATA_W-1:0]        busRdata,
  // timer A mode
  input  wire logic                               splitMode,
  // peripheral side
  input  wire pprs_pkg::pprs_route_t              periphOut,
  input  wire pprs_pkg::pprs_route_t              periphOe,
  output      pprs_pkg::pprs_route_t              periphIn,
  input  wire pprs_pkg::pprs_event_t              eventOut,
  // default pins
  output      pprs_pkg::pprs_route_t              pinDefOut,
  output      pprs_pkg::pprs_route_t              pinDefOe,
  input  wire pprs_pkg::pprs_route_t              pinDefIn,
  // alternative pins
  output      pprs_pkg::pprs_route_t              pinAltOut,
  output      pprs_pkg::pprs_route_t              pinAltOe,
  input  wire pprs_pkg::pprs_route_t              pinAltIn,
  // event pins
  output      pprs_pkg::pprs_event_t              eventPinOut,
  output      pprs_pkg::pprs_event_t              eventPinOe
);
  import pprs_pkg::*;

  // ===========================================================
  // routing registers

  logic [DATA_W-1:0] logicEvents_reg;
  logic [DATA_W-1:0] commPorts_reg;
  logic [DATA_W-1:0] timerA_reg;
  logic [DATA_W-1:0] timerB_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // masks keep unassigned bits at zero whatever is written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      logicEvents_reg <= RST_VAL;
    end else if (busWe && busAddr == OFS_LOGIC_EVENTS) begin
      logicEvents_reg <= busWdata & MASK_LOGIC;
    end
  end

  // comm pin set selects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      commPorts_reg <= RST_VAL;
    end else if (busWe && busAddr == OFS_COMM_PORTS) begin
      commPorts_reg <= busWdata & MASK_COMM;
    end
  end

  // timer A wave selects; stored even in normal mode so a later
  // switch to split mode picks them up without a rewrite
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerA_reg <= RST_VAL;
    end else if (busWe && busAddr == OFS_TIMER_A) begin
      timerA_reg <= busWdata & MASK_TIMER_A;
    end
  end

  // timer B output select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerB_reg <= RST_VAL;
    end else if (busWe && busAddr == OFS_TIMER_B) begin
      timerB_reg <= busWdata & MASK_TIMER_B;
    end
  end

  // ===========================================================
  // read path

  // unmapped offsets read zero
  always_comb begin
    case (busAddr)
      OFS_LOGIC_EVENTS: rdata_next = logicEvents_reg;
      OFS_COMM_PORTS:   rdata_next = commPorts_reg;
      OFS_TIMER_A:      rdata_next = timerA_reg;
      OFS_TIMER_B:      rdata_next = timerB_reg;
      default:          rdata_next = RST_VAL;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RST_VAL;
    end else if (busRe) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= RST_VAL;
    end
  end

  assign busRdata = rdata_reg;

  // ===========================================================
  // select decode

  pprs_route_if rif ();

  // selects come straight from the registers, so a write shows at the
  // pins in the cycle after the strobe
  assign rif.routeAlt[LUT_BASE +: N_LUT] =
    logicEvents_reg[LUT_BIT +: N_LUT];

  assign rif.eventEn = logicEvents_reg[EVENT_BIT +: N_EVENT];

  // low three waves route in both modes; in split mode they are the
  // low-byte compare outputs, which the timer itself presents here
  assign rif.routeAlt[WAVE_BASE +: N_WAVE_FIXED] =
    timerA_reg[WAVE_BIT +: N_WAVE_FIXED];

  // upper three waves exist only in split mode
  assign rif.routeAlt[WAVE_BASE + N_WAVE_FIXED +: N_WAVE_SPLIT] =
    timerA_reg[WAVE_BIT + N_WAVE_FIXED +: N_WAVE_SPLIT] &
    {N_WAVE_SPLIT{splitMode}};

  assign rif.routeAlt[TB_BASE] = timerB_reg[TIMER_B_BIT];

  // one select bit moves every signal of a comm instance together
  genvar k;
  generate
    for (k = 0; k < N_COMM; k++) begin : g_comm
      assign rif.routeAlt[COMM_BASE + k*COMM_SIGS +: COMM_SIGS] =
        {COMM_SIGS{commPorts_reg[k*COMM_BIT_STEP]}};
    end
  endgenerate

  // ===========================================================
  // pin multiplexer

  pprs_route_mux i_pprs_route_mux (
    .clk      (clk),
    .rst_n    (rst_n),
    .rif      (rif.mux),
    .sigOut   (periphOut),
    .sigOe    (periphOe),
    .sigIn    (periphIn),
    .evOut    (eventOut),
    .defOut   (pinDefOut),
    .defOe    (pinDefOe),
    .defIn    (pinDefIn),
    .altOut   (pinAltOut),
    .altOe    (pinAltOe),
    .altIn    (pinAltIn),
    .evPinOut (eventPinOut),
    .evPinOe  (eventPinOe)
  );

  // ===========================================================
  // checks

  // lookup table 1 follows its select
  a_table1_route: assert property (@(posedge clk) disable iff (!rst_n)
    pinAltOe[LUT_BASE+1] == (logicEvents_reg[LUT_BIT+1] & periphOe[LUT_BASE+1]) &&
    pinDefOe[LUT_BASE+1] == (!logicEvents_reg[LUT_BIT+1] & periphOe[LUT_BASE+1]))
    else $error("lookup table 1 route wrong");

  // lookup table 0 follows its select
  a_table0_route: assert property (@(posedge clk) disable iff (!rst_n)
    logicEvents_reg[LUT_BIT] |->
      pinAltOut[LUT_BASE] == periphOut[LUT_BASE] && !pinDefOe[LUT_BASE])
    else $error("lookup table 0 alternative route wrong");

  // event 2 pin released while disabled
  a_event2_off: assert property (@(posedge clk) disable iff (!rst_n)
    !logicEvents_reg[EVENT_BIT+2] |-> !eventPinOe[2] && !eventPinOut[2])
    else $error("event 2 driven while disabled");

  // event 1 pin copies the event while enabled
  a_event1_on: assert property (@(posedge clk) disable iff (!rst_n)
    logicEvents_reg[EVENT_BIT+1] |-> eventPinOe[1] && eventPinOut[1] == eventOut[1])
    else $error("event 1 not driven while enabled");

  // event 0 enable follows a write one cycle later
  a_event0_write: assert property (@(posedge clk) disable iff (!rst_n)
    busWe && busAddr == OFS_LOGIC_EVENTS |=> eventPinOe[0] == $past(busWdata[EVENT_BIT]))
    else $error("event 0 enable not taken from write");

  // two-wire instance moves as a group
  a_twi_group: assert property (@(posedge clk) disable iff (!rst_n)
    commPorts_reg[2*COMM_BIT_STEP] |->
      pinAltOe[COMM_BASE+2*COMM_SIGS +: COMM_SIGS] == periphOe[COMM_BASE+2*COMM_SIGS +: COMM_SIGS] &&
      pinDefOe[COMM_BASE+2*COMM_SIGS +: COMM_SIGS] == '0)
    else $error("two-wire pins not on alternative set");

  // spi instance on default set while bit clear
  a_spi_group: assert property (@(posedge clk) disable iff (!rst_n)
    !commPorts_reg[COMM_BIT_STEP] |->
      pinDefOut[COMM_BASE+COMM_SIGS +: COMM_SIGS] == periphOut[COMM_BASE+COMM_SIGS +: COMM_SIGS] &&
      pinAltOe[COMM_BASE+COMM_SIGS +: COMM_SIGS] == '0)
    else $error("spi pins not on default set");

  // serial port input taken from the selected pin set two cycles back
  a_usart_input: assert property (@(posedge clk) disable iff (!rst_n)
    commPorts_reg[0] && $past(commPorts_reg[0]) && $past(commPorts_reg[0], 2) |->
      periphIn[COMM_BASE] == $past(pinAltIn[COMM_BASE], 2))
    else $error("serial port input not from alternative pin");

  // split-mode wave 5 on its alternative pin
  a_split_waves: assert property (@(posedge clk) disable iff (!rst_n)
    splitMode && timerA_reg[WAVE_BIT+5] |-> pinAltOe[WAVE_BASE+5] == periphOe[WAVE_BASE+5])
    else $error("wave 5 not on alternative pin in split mode");

  // wave 4 follows its bit in split mode
  a_wave4_split: assert property (@(posedge clk) disable iff (!rst_n)
    splitMode && timerA_reg[WAVE_BIT+4] |-> !pinDefOe[WAVE_BASE+4])
    else $error("wave 4 still on default pin in split mode");

  // wave 3 follows its bit in split mode
  a_wave3_split: assert property (@(posedge clk) disable iff (!rst_n)
    splitMode && timerA_reg[WAVE_BIT+3] |-> pinAltOut[WAVE_BASE+3] == periphOut[WAVE_BASE+3])
    else $error("wave 3 not routed in split mode");

  // upper waves stay on default pins in normal mode
  a_normal_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !splitMode |->
      pinDefOe[WAVE_BASE+3 +: 3] == periphOe[WAVE_BASE+3 +: 3] && pinAltOe[WAVE_BASE+3 +: 3] == '0)
    else $error("upper waves moved in normal mode");

  // lower waves route regardless of mode
  a_low_waves: assert property (@(posedge clk) disable iff (!rst_n)
    pinAltOe[WAVE_BASE +: 3] == (timerA_reg[WAVE_BIT +: 3] & periphOe[WAVE_BASE +: 3]))
    else $error("lower wave routing wrong");

  // timer B output follows its select
  a_timer_b: assert property (@(posedge clk) disable iff (!rst_n)
    pinAltOe[TB_BASE] == (timerB_reg[TIMER_B_BIT] & periphOe[TB_BASE]))
    else $error("timer B route wrong");

  // reset leaves every register at zero
  a_reset_zero: assert property (@(posedge clk)
    $rose(rst_n) |->
      {logicEvents_reg, commPorts_reg, timerA_reg, timerB_reg} == '0 && eventPinOe == '0)
    else $error("routing state not zero after reset");

  // default and alternative never both carry a route
  a_one_position: assert property (@(posedge clk) disable iff (!rst_n)
    (pinDefOe & pinAltOe) == '0)
    else $error("route enabled on both pins");

  // unassigned bits read back zero
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    busRe ##1 1'b1 |->
      (busRdata & ~($past(busAddr) == OFS_LOGIC_EVENTS ? MASK_LOGIC :
                    $past(busAddr) == OFS_COMM_PORTS   ? MASK_COMM :
                    $past(busAddr) == OFS_TIMER_A      ? MASK_TIMER_A : MASK_TIMER_B)) == '0)
    else $error("unassigned bit read as one");

  // timer B select changes only in the cycle after a write to it
  a_next_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(timerB_reg) |-> $past(busWe) && $past(busAddr) == OFS_TIMER_B)
    else $error("select changed without a write");

  // a write to the comm register leaves the timer A and logic/event registers alone
  a_no_cross: assert property (@(posedge clk) disable iff (!rst_n)
    busWe && busAddr == OFS_COMM_PORTS |=> $stable(timerA_reg) && $stable(logicEvents_reg))
    else $error("write disturbed another register");

  // read data stands only one cycle
  a_read_once: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(busRe) |-> busRdata == '0)
    else $error("read data outside its cycle");

  // lookup table 1 keeps its default pin while the bit is clear
  a_table1_home: assert property (@(posedge clk) disable iff (!rst_n)
    !logicEvents_reg[LUT_BIT+1] |->
      pinDefOut[LUT_BASE+1] == periphOut[LUT_BASE+1] && !pinAltOe[LUT_BASE+1])
    else $error("lookup table 1 left its default pin");

  // lookup table 0 keeps its default pin while the bit is clear
  a_table0_home: assert property (@(posedge clk) disable iff (!rst_n)
    !logicEvents_reg[LUT_BIT] |->
      pinDefOe[LUT_BASE] == periphOe[LUT_BASE] && !pinAltOut[LUT_BASE])
    else $error("lookup table 0 left its default pin");

  // event 2 pin copies the event while enabled
  a_event2_on: assert property (@(posedge clk) disable iff (!rst_n)
    logicEvents_reg[EVENT_BIT+2] |-> eventPinOe[2] && eventPinOut[2] == eventOut[2])
    else $error("event 2 not driven while enabled");

  // event 1 pin released while disabled
  a_event1_off: assert property (@(posedge clk) disable iff (!rst_n)
    !logicEvents_reg[EVENT_BIT+1] |-> !eventPinOe[1] && !eventPinOut[1])
    else $error("event 1 driven while disabled");

  // event 0 pin tracks its enable in both states
  a_event0_state: assert property (@(posedge clk) disable iff (!rst_n)
    eventPinOe[0] == logicEvents_reg[EVENT_BIT] &&
    eventPinOut[0] == (logicEvents_reg[EVENT_BIT] & eventOut[0]))
    else $error("event 0 pin does not follow its enable");

  // two-wire instance stays on the default set while its bit is clear
  a_twi_home: assert property (@(posedge clk) disable iff (!rst_n)
    !commPorts_reg[2*COMM_BIT_STEP] |->
      pinDefOe[COMM_BASE+2*COMM_SIGS +: COMM_SIGS] == periphOe[COMM_BASE+2*COMM_SIGS +: COMM_SIGS] &&
      pinAltOe[COMM_BASE+2*COMM_SIGS +: COMM_SIGS] == '0)
    else $error("two-wire pins moved with bit clear");

  // spi instance moves as a group when its bit is set
  a_spi_away: assert property (@(posedge clk) disable iff (!rst_n)
    commPorts_reg[COMM_BIT_STEP] |->
      pinAltOut[COMM_BASE+COMM_SIGS +: COMM_SIGS] == periphOut[COMM_BASE+COMM_SIGS +: COMM_SIGS] &&
      pinDefOe[COMM_BASE+COMM_SIGS +: COMM_SIGS] == '0)
    else $error("spi pins not on alternative set");

  // serial port outputs move as a group when its bit is set
  a_serial_group: assert property (@(posedge clk) disable iff (!rst_n)
    commPorts_reg[0] |->
      pinAltOe[COMM_BASE +: COMM_SIGS] == periphOe[COMM_BASE +: COMM_SIGS] &&
      pinDefOut[COMM_BASE +: COMM_SIGS] == '0)
    else $error("serial port pins not on alternative set");

  // timer B output stays on its default pin while the bit is clear
  a_timer_b_home: assert property (@(posedge clk) disable iff (!rst_n)
    !timerB_reg[TIMER_B_BIT] |-> pinDefOut[TB_BASE] == periphOut[TB_BASE] && !pinAltOe[TB_BASE])
    else $error("timer B left its default pin");

  // a timer A write is held, masked, from the very next cycle
  a_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    busWe && busAddr == OFS_TIMER_A |=> timerA_reg == ($past(busWdata) & MASK_TIMER_A))
    else $error("timer A write not taken");

  // the master never reads and writes at once, so the value read is the one held
  a_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
    busRe && busAddr == OFS_COMM_PORTS |=> busRdata == $past(commPorts_reg))
    else $error("comm register read back wrong");

endmodule

// [dv/pprs_pin_side_model.sv]
// model of the routed peripherals and the package pins around the pin route block
`timescale 1ns/10ps
module pprs_pin_side_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // pin input stepping
  input  wire logic                  step,
  // peripheral side
  output      pprs_pkg::pprs_route_t periphOut,
  output      pprs_pkg::pprs_route_t periphOe,
  output      pprs_pkg::pprs_event_t eventOut,
  // package pins
  output      pprs_pkg::pprs_route_t pinDefIn,
  output      pprs_pkg::pprs_route_t pinAltIn
);
  import pprs_pkg::*;
  // ===========================================================
  // peripherals
  // values move every cycle so a stale or swapped route shows at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periphOut <= 21'h0a5a5a;
      periphOe  <= 21'h1c3c3c;
      eventOut  <= 3'h5;
    end else begin
      periphOut <= {periphOut[19:0], ~periphOut[20]};
      periphOe  <= {periphOe[0], periphOe[20:1]};
      eventOut  <= eventOut + 3'h1;
    end
  end
  // ===========================================================
  // pins
  // inputs change only on request, so the synchroniser delay can be judged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinDefIn <= 21'h0f0f0f;
      pinAltIn <= 21'h135795;
    end else if (step) begin
      pinDefIn <= ~{pinDefIn[0], pinDefIn[20:1]};
      pinAltIn <= pinDefIn ^ 21'h15aa55;
    end
  end
endmodule

// [dv/test_pprs_pin_route_block.sv]
// self-checking bench for the pin route block
`timescale 1ns/10ps
module test_pprs_pin_route_block;
  import pprs_pkg::*;
  // ===========================================================
  // signals
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [ADDR_W-1:0]   busAddr = 4'h0;
  logic [DATA_W-1:0]   busWdata = 8'h00;
  logic                busWe = 1'b0;
  logic                busRe = 1'b0;
  logic [DATA_W-1:0]   busRdata;
  logic                splitMode = 1'b0;
  logic                step = 1'b0;
  pprs_route_t         periphOut, periphOe, periphIn, pinDefOut, pinDefOe, pinDefIn;
  pprs_route_t         pinAltOut, pinAltOe, pinAltIn;
  pprs_event_t         eventOut, eventPinOut, eventPinOe;
  logic [DATA_W-1:0]   sh [4];
  int                  nErrors = 0;
  int                  numChecks = 0;
  localparam logic [DATA_W-1:0] MASKS [4] = '{MASK_LOGIC, MASK_COMM, MASK_TIMER_A, MASK_TIMER_B};

  // 125 MHz clock
  always #4 clk = ~clk;

  pprs_pin_route_block i_pprs_pin_route_block (
    .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata), .busWe(busWe), .busRe(busRe),
    .busRdata(busRdata), .splitMode(splitMode), .periphOut(periphOut), .periphOe(periphOe),
    .periphIn(periphIn), .eventOut(eventOut), .pinDefOut(pinDefOut), .pinDefOe(pinDefOe),
    .pinDefIn(pinDefIn), .pinAltOut(pinAltOut), .pinAltOe(pinAltOe), .pinAltIn(pinAltIn),
    .eventPinOut(eventPinOut), .eventPinOe(eventPinOe));

  pprs_pin_side_model i_pprs_pin_side_model (
    .clk(clk), .rst_n(rst_n), .step(step), .periphOut(periphOut), .periphOe(periphOe),
    .eventOut(eventOut), .pinDefIn(pinDefIn), .pinAltIn(pinAltIn));

  // ===========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // alternative-pin selection expected from the shadow registers
  function automatic pprs_route_t expSel();
    pprs_route_t s;
    s = '0;
    s[1:0]   = sh[0][5:4];
    s[4:2]   = sh[2][2:0];
    s[7:5]   = sh[2][5:3] & {3{splitMode}};
    s[8]     = sh[3][0];
    s[12:9]  = {4{sh[1][0]}};
    s[16:13] = {4{sh[1][2]}};
    s[20:17] = {4{sh[1][4]}};
    return s;
  endfunction

  // the shadow keeps only implemented bits, unmapped writes leave it alone
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    busWe    <= 1'b1;
    busAddr  <= a;
    busWdata <= d;
    @(posedge clk);
    busWe    <= 1'b0;
    if (a < 4'h4) sh[a[1:0]] = d & MASKS[a[1:0]];
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    busRe   <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRe   <= 1'b0;
    @(negedge clk);
    chk(busRdata, exp);
  endtask

  // pin outputs judged mid-cycle against the selection from the shadow
  task automatic checkPins();
    pprs_route_t s;
    @(negedge clk);
    s = expSel();
    chk(pinAltOut, periphOut & s);
    chk(pinAltOe, periphOe & s);
    chk(pinDefOut, periphOut & ~s);
    chk(pinDefOe, periphOe & ~s);
    chk(eventPinOe, sh[0][2:0]);
    chk(eventPinOut, eventOut & sh[0][2:0]);
  endtask

  // ===========================================================
  // scenarios
  task automatic tReset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) sh[i] = 8'h00;
    checkPins();
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'h00);
  endtask

  // all ones, then unmapped offsets must neither store nor answer
  task automatic tAccess();
    for (int i = 0; i < 4; i++) begin
      wr(i[3:0], 8'hff);
      checkPins();
      rd(i[3:0], MASKS[i]);
    end
    wr(4'h4, 8'h00);
    wr(4'hf, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h0, MASKS[0]);
  endtask

  // every bit alone, in both timer modes
  task automatic tBits();
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      splitMode <= m[0];
      for (int r = 0; r < 4; r++) begin
        for (int b = 0; b < 8; b++) begin
          wr(r[3:0], 8'h01 << b);
          checkPins();
        end
        wr(r[3:0], 8'h00);
      end
    end
  endtask

  // stored wave 3..5 bits apply as soon as split mode is entered
  task automatic tSplit();
    wr(4'h2, 8'h38);
    @(posedge clk);
    splitMode <= 1'b0;
    checkPins();
    @(posedge clk);
    splitMode <= 1'b1;
    checkPins();
    rd(4'h2, 8'h38);
  endtask

  // inputs come back from the selected pin after the synchroniser
  task automatic tInput(input logic [DATA_W-1:0] comm);
    pprs_route_t s;
    wr(4'h1, comm);
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    s = expSel();
    chk(periphIn, (pinAltIn & s) | (pinDefIn & ~s));
  endtask

  // ===========================================================
  // verdict and run
  task automatic endSim();
    if (nErrors == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    nErrors++;
    endSim();
  end

  initial begin
    tReset();
    tAccess();
    tBits();
    tSplit();
    tInput(8'h15);
    tInput(8'h04);
    wr(4'h0, 8'h37);
    tReset();
    endSim();
  end
endmodule
